//--- inc/cog_decode_pkg.sv
// shared constants and types for the core condition and effect decoder
package cog_decode_pkg;

	localparam int unsigned DATA_W           = 32;
	localparam int unsigned ADDR_W           = 9;
	localparam int unsigned RAM_DEPTH        = 512;
	localparam int unsigned CNT_W            = 5;

	localparam logic [8:0]  GENERAL_LAST_ADDR  = 9'h1ef;
	localparam logic [8:0]  SPECIAL_FIRST_ADDR = 9'h1f0;

	// instruction word fields
	localparam int unsigned OPC_MSB          = 31;
	localparam int unsigned OPC_LSB          = 26;
	localparam int unsigned ZERO_EFF_BIT     = 25;
	localparam int unsigned CARRY_EFF_BIT    = 24;
	localparam int unsigned RESULT_EFF_BIT   = 23;
	localparam int unsigned IMM_BIT          = 22;
	localparam int unsigned COND_MSB         = 21;
	localparam int unsigned COND_LSB         = 18;
	localparam int unsigned DEST_MSB         = 17;
	localparam int unsigned DEST_LSB         = 9;
	localparam int unsigned SRC_MSB          = 8;
	localparam int unsigned SRC_LSB          = 0;

	localparam logic [5:0]  DECREMENT_BRANCH_NONZERO_OPC = 6'h39;
	localparam logic [5:0]  SHARED_HUB_OPERATION_OPC     = 6'h03;

	localparam logic [3:0]  COND_IF_ZERO     = 4'ha;
	localparam logic [3:0]  COND_IF_NZERO    = 4'h5;
	localparam logic [3:0]  COND_IF_CARRY    = 4'hc;
	localparam logic [3:0]  COND_IF_NCARRY   = 4'h3;

	// cycle counts per instruction at 125 MHz
	localparam int unsigned SHORT_CYCLES     = 4;
	localparam int unsigned LONG_CYCLES      = 8;
	localparam int unsigned HUB_MIN_CYCLES   = 7;
	localparam int unsigned HUB_MAX_CYCLES   = 22;

	// apb register byte offsets
	localparam logic [7:0]  CTRL_OFS         = 8'h00;
	localparam logic [7:0]  INSTR_OFS        = 8'h04;
	localparam logic [7:0]  STATUS_OFS       = 8'h08;
	localparam logic [7:0]  RAM_ADDR_OFS     = 8'h0c;
	localparam logic [7:0]  RAM_DATA_OFS     = 8'h10;

	localparam int unsigned CTRL_GO_BIT      = 0;
	localparam int unsigned STAT_BUSY_BIT    = 0;
	localparam int unsigned STAT_ZERO_BIT    = 1;
	localparam int unsigned STAT_CARRY_BIT   = 2;
	localparam int unsigned STAT_EXEC_BIT    = 3;
	localparam int unsigned STAT_PC_LSB      = 16;

	localparam logic [31:0] INSTR_RESET      = 32'h0000_0000;
	localparam logic [8:0]  PC_RESET         = 9'h000;

	typedef enum logic [2:0] {
		clock_setting_op = 3'h0,
		core_identity_op = 3'h1,
		core_start_op    = 3'h2,
		core_halt_op     = 3'h3,
		lock_checkout_op = 3'h4,
		lock_release_op  = 3'h5,
		lock_assert_op   = 3'h6,
		lock_deassert_op = 3'h7
	} hub_op_t;

	typedef enum logic [2:0] {
		ST_IDLE     = 3'b001,
		ST_EXEC     = 3'b010,
		ST_HUB_WAIT = 3'b100
	} exec_state_t;

endpackage

//--- design/cog_ram.sv
// core memory with registered read data
`timescale 1ns/10ps
module cog_ram #(
	parameter int unsigned DEPTH = 512,
	parameter int unsigned WIDTH = 32,
	parameter int unsigned AW    = 9
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             we,
	input  wire logic [AW-1:0]    addr,
	input  wire logic [WIDTH-1:0] wdata,
	output logic      [WIDTH-1:0] rdata
);

	logic [WIDTH-1:0] mem [DEPTH];

	always_ff @(posedge clk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
	end

	// read returns the old word on a same-cycle write
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= '0;
		end else begin
			rdata <= mem[addr];
		end
	end

endmodule

//--- design/cog_condition_effect_decode.sv
// condition, effect and branch/hub execute control of one core
//
// The address map and register access over APB are this design's own decisions.
`timescale 1ns/10ps
module cog_condition_effect_decode
	import cog_decode_pkg::*;
(
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	output logic                   hub_req,
	output logic      [2:0]        hub_op,
	output logic      [DATA_W-1:0] hub_operand,
	input  wire logic              hub_ack,
	input  wire logic [DATA_W-1:0] hub_result,
	input  wire logic              hub_carry,
	output logic                   busy,
	output logic                   exec_done
);

	exec_state_t       state_reg, state_next;
	logic [CNT_W-1:0]  cnt_reg;
	logic [31:0]       instr_reg;
	logic [DATA_W-1:0] d_reg, s_reg, hres_reg;
	logic              hcarry_reg, ack_seen_reg;
	logic              z_reg, c_reg, executed_reg;
	logic [8:0]        pc_reg, ram_addr_reg;
	logic [2:0]        hub_op_reg;
	logic [DATA_W-1:0] hub_operand_reg;
	logic [DATA_W-1:0] mem_rdata;

	// apb decode
	wire apb_acc   = psel && penable;
	wire sel_ctrl  = paddr == CTRL_OFS;
	wire sel_instr = paddr == INSTR_OFS;
	wire sel_stat  = paddr == STATUS_OFS;
	wire sel_raddr = paddr == RAM_ADDR_OFS;
	wire sel_rdata = paddr == RAM_DATA_OFS;
	wire mapped    = sel_ctrl || sel_instr || sel_stat || sel_raddr || sel_rdata;
	wire is_busy   = state_reg != ST_IDLE;
	wire load_over = sel_rdata && pwrite && (ram_addr_reg > GENERAL_LAST_ADDR);
	wire apb_err   = !mapped || (is_busy && (pwrite || sel_rdata)) || load_over;
	wire apb_wr_ok = apb_acc && pwrite && !apb_err;
	wire apb_rd_ok = apb_acc && !pwrite && !apb_err;
	wire start     = apb_wr_ok && sel_ctrl && pwdata[CTRL_GO_BIT];
	wire ram_apb_we = apb_wr_ok && sel_rdata;

	// instruction fields
	wire [5:0] opc     = instr_reg[OPC_MSB:OPC_LSB];
	wire       z_eff   = instr_reg[ZERO_EFF_BIT];
	wire       c_eff   = instr_reg[CARRY_EFF_BIT];
	wire       r_eff   = instr_reg[RESULT_EFF_BIT];
	wire       imm     = instr_reg[IMM_BIT];
	wire [3:0] cond    = instr_reg[COND_MSB:COND_LSB];
	wire [8:0] dest    = instr_reg[DEST_MSB:DEST_LSB];
	wire [8:0] src     = instr_reg[SRC_MSB:SRC_LSB];

	wire cond_ok  = cond[{c_reg, z_reg}];
	wire is_dec   = opc == DECREMENT_BRANCH_NONZERO_OPC;
	wire is_hub   = opc == SHARED_HUB_OPERATION_OPC;
	wire exec_hub = is_hub && cond_ok;

	// source operand, register or 9-bit literal
	wire [DATA_W-1:0] s_src   = imm ? {23'h0, src} : mem_rdata;
	wire [DATA_W-1:0] dec_res = d_reg - 32'h1;
	wire              borrow  = d_reg == '0;
	wire              taken   = dec_res != '0;
	wire              fall    = is_dec && cond_ok && !taken;

	wire [CNT_W-1:0] short_last = CNT_W'(SHORT_CYCLES - 1);
	wire [CNT_W-1:0] long_last  = CNT_W'(LONG_CYCLES - 1);
	wire [CNT_W-1:0] hub_last   = CNT_W'(HUB_MIN_CYCLES - 1);
	wire [CNT_W-1:0] last_cnt   = fall ? long_last : short_last;
	wire [CNT_W-1:0] hub_issue  = CNT_W'(SHORT_CYCLES - 2);

	wire fin_plain = (state_reg == ST_EXEC) && !exec_hub && (cnt_reg == last_cnt);
	wire fin_hub   = (state_reg == ST_HUB_WAIT) && ack_seen_reg && (cnt_reg >= hub_last);
	wire fin       = fin_plain || fin_hub;

	// effect bits steer the flag and result updates
	wire do_exec  = fin && cond_ok;
	wire upd_z    = do_exec && z_eff && (is_dec || is_hub);
	wire upd_c    = do_exec && c_eff && (is_dec || is_hub);
	wire z_val    = is_dec ? (dec_res == '0) : (hres_reg == '0);
	wire c_val    = is_dec ? borrow : hcarry_reg;
	wire res_we   = do_exec && r_eff && (is_dec || is_hub);
	wire [DATA_W-1:0] res_val = is_dec ? dec_res : hres_reg;
	wire [8:0]  pc_next = (do_exec && is_dec && taken) ? s_reg[8:0] : pc_reg + 9'h1;

	// memory port: operand reads then result write, apb when idle
	wire        ex_rd_src = (state_reg == ST_EXEC) && (cnt_reg == CNT_W'(1));
	wire [8:0]  mem_addr  = !is_busy ? ram_addr_reg : (ex_rd_src ? src : dest);
	wire        mem_we    = res_we || ram_apb_we;
	wire [DATA_W-1:0] mem_wdata = is_busy ? res_val : pwdata;

	cog_ram #(
		.DEPTH (RAM_DEPTH),
		.WIDTH (DATA_W),
		.AW    (ADDR_W)
	) u_ram (
		.clk   (pclk),
		.rst_n (presetn),
		.we    (mem_we),
		.addr  (mem_addr),
		.wdata (mem_wdata),
		.rdata (mem_rdata)
	);

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (start) begin
					state_next = ST_EXEC;
				end
			end
			ST_EXEC: begin
				if (fin_plain) begin
					state_next = ST_IDLE;
				end else if (exec_hub && cnt_reg == hub_issue) begin
					state_next = ST_HUB_WAIT;
				end
			end
			ST_HUB_WAIT: begin
				if (fin_hub) begin
					state_next = ST_IDLE;
				end
			end
			default: state_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= ST_IDLE;
			cnt_reg   <= '0;
		end else begin
			state_reg <= state_next;
			cnt_reg   <= (state_next == ST_IDLE || start) ? '0 : cnt_reg + CNT_W'(1);
		end
	end

	// operand capture
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			d_reg           <= '0;
			s_reg           <= '0;
			hub_op_reg      <= '0;
			hub_operand_reg <= '0;
		end else if (state_reg == ST_EXEC) begin
			if (cnt_reg == CNT_W'(1)) begin
				d_reg <= mem_rdata;
			end
			if (cnt_reg == hub_issue) begin
				s_reg           <= s_src;
				hub_op_reg      <= s_src[2:0];
				hub_operand_reg <= d_reg;
			end
		end
	end

	// hub answer capture
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ack_seen_reg <= 1'b0;
			hres_reg     <= '0;
			hcarry_reg   <= 1'b0;
		end else if (state_reg != ST_HUB_WAIT) begin
			ack_seen_reg <= 1'b0;
		end else if (hub_ack && !ack_seen_reg) begin
			ack_seen_reg <= 1'b1;
			hres_reg     <= hub_result;
			hcarry_reg   <= hub_carry;
		end
	end

	// flags and program counter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			z_reg        <= 1'b0;
			c_reg        <= 1'b0;
			pc_reg       <= PC_RESET;
			executed_reg <= 1'b0;
		end else if (fin) begin
			z_reg        <= upd_z ? z_val : z_reg;
			c_reg        <= upd_c ? c_val : c_reg;
			pc_reg       <= pc_next;
			executed_reg <= cond_ok;
		end else if (apb_wr_ok && sel_stat) begin
			z_reg  <= pwdata[STAT_ZERO_BIT];
			c_reg  <= pwdata[STAT_CARRY_BIT];
			pc_reg <= pwdata[STAT_PC_LSB +: 9];
		end
	end

	// software registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			instr_reg    <= INSTR_RESET;
			ram_addr_reg <= '0;
		end else begin
			if (apb_wr_ok && sel_instr) begin
				instr_reg <= pwdata;
			end
			if (apb_wr_ok && sel_raddr) begin
				ram_addr_reg <= pwdata[8:0];
			end else if ((apb_wr_ok || apb_rd_ok) && sel_rdata) begin
				ram_addr_reg <= ram_addr_reg + 9'h1;
			end
		end
	end

	wire [31:0] status_word = {7'h0, pc_reg, 12'h0, executed_reg, c_reg, z_reg, is_busy};
	wire [31:0] rd_mux = sel_instr ? instr_reg :
	                     sel_stat  ? status_word :
	                     sel_raddr ? {23'h0, ram_addr_reg} :
	                     sel_rdata ? mem_rdata : 32'h0;

	assign prdata      = apb_rd_ok ? rd_mux : 32'h0;
	assign pready      = 1'b1;
	assign pslverr     = apb_acc && apb_err;
	assign hub_req     = (state_reg == ST_HUB_WAIT) && !ack_seen_reg;
	assign hub_op      = hub_op_reg;
	assign hub_operand = hub_operand_reg;
	assign busy        = is_busy;
	assign exec_done   = fin;

	// assertions
	property p_nop_len;
		@(posedge pclk) disable iff (!presetn) fin && !cond_ok |-> cnt_reg == 5'd3;
	endproperty
	a_nop_len: assert property (p_nop_len) else $error("false condition not four cycles");

	property p_nop_flags;
		@(posedge pclk) disable iff (!presetn) fin && !cond_ok |-> !mem_we ##1 $stable(z_reg) && $stable(c_reg);
	endproperty
	a_nop_flags: assert property (p_nop_flags) else $error("false condition changed state");

	property p_if_zero;
		@(posedge pclk) disable iff (!presetn) fin && cond == COND_IF_ZERO |=> executed_reg == $past(z_reg);
	endproperty
	a_if_zero: assert property (p_if_zero) else $error("zero condition misjudged");

	property p_if_carry;
		@(posedge pclk) disable iff (!presetn) fin && cond == COND_IF_CARRY |=> executed_reg == $past(c_reg);
	endproperty
	a_if_carry: assert property (p_if_carry) else $error("carry condition misjudged");

	property p_dec_taken;
		@(posedge pclk) disable iff (!presetn) start ##1 (is_dec && cond_ok) [*3] ##1 taken |-> fin;
	endproperty
	a_dec_taken: assert property (p_dec_taken) else $error("taken branch not four cycles");

	property p_dec_fall;
		@(posedge pclk) disable iff (!presetn) fin && is_dec && cond_ok && !taken |-> cnt_reg == 5'd7;
	endproperty
	a_dec_fall: assert property (p_dec_fall) else $error("fall-through not eight cycles");

	property p_dec_pc;
		@(posedge pclk) disable iff (!presetn) fin && is_dec && cond_ok && taken |=> pc_reg == s_reg[8:0];
	endproperty
	a_dec_pc: assert property (p_dec_pc) else $error("branch target not loaded");

	property p_dec_zero;
		@(posedge pclk) disable iff (!presetn) fin && is_dec && cond_ok && z_eff |=> z_reg == ($past(d_reg) == 32'h1);
	endproperty
	a_dec_zero: assert property (p_dec_zero) else $error("zero flag wrong after decrement");

	property p_no_flag_eff;
		@(posedge pclk) disable iff (!presetn) fin && !z_eff && !c_eff |=> $stable(z_reg) && $stable(c_reg);
	endproperty
	a_no_flag_eff: assert property (p_no_flag_eff) else $error("flags moved without effect");

	property p_hub_len;
		@(posedge pclk) disable iff (!presetn) fin && is_hub && cond_ok |-> cnt_reg >= 5'd6 && cnt_reg <= 5'd21;
	endproperty
	a_hub_len: assert property (p_hub_len) else $error("hub operation length out of range");

	property p_load_limit;
		@(posedge pclk) disable iff (!presetn) ram_apb_we |-> mem_addr <= GENERAL_LAST_ADDR;
	endproperty
	a_load_limit: assert property (p_load_limit) else $error("load beyond general memory");

	c_dec_taken: cover property (@(posedge pclk) fin && is_dec && cond_ok && taken);
	c_dec_fall: cover property (@(posedge pclk) fin && is_dec && cond_ok && !taken);
	c_hub_done: cover property (@(posedge pclk) fin && is_hub && cond_ok && r_eff);
	c_nop: cover property (@(posedge pclk) fin && !cond_ok);

endmodule

//--- dv/hub_model.sv
// shared hub model answering core hub requests after a set delay
`timescale 1ns/10ps
module hub_model (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        hub_req,
	input  wire logic [4:0]  delay,
	input  wire logic [31:0] result_val,
	input  wire logic        carry_val,
	output logic             hub_ack,
	output logic      [31:0] hub_result,
	output logic             hub_carry
);
	logic [4:0] wait_cnt;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wait_cnt   <= 5'h0;
			hub_ack    <= 1'b0;
			hub_result <= 32'h0;
			hub_carry  <= 1'b0;
		end else if (!hub_ack && hub_req && wait_cnt == delay) begin
			hub_ack    <= 1'b1;
			hub_result <= result_val;
			hub_carry  <= carry_val;
		end else begin
			hub_ack    <= 1'b0;
			hub_result <= ~hub_result;
			hub_carry  <= ~hub_carry;
			wait_cnt   <= (hub_req && !hub_ack) ? wait_cnt + 5'h1 : 5'h0;
		end
	end
endmodule

//--- dv/cog_condition_effect_decode_tb.sv
// self-checking bench for the core condition, effect and hub control
`timescale 1ns/10ps
module cog_condition_effect_decode_tb import cog_decode_pkg::*;;
	logic        pclk, presetn, psel, penable, pwrite, err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, hub_operand, hub_result, result_val, rd, seen_operand;
	logic        pready, pslverr, hub_req, hub_ack, hub_carry, carry_val, busy, exec_done;
	logic [2:0]  hub_op, seen_op;
	logic [4:0]  delay;
	logic [3:0]  cnd;
	logic [1:0]  fl;
	int          mismatches, num_checks, busy_cycles, done_pulses;

	cog_condition_effect_decode dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .hub_req(hub_req), .hub_op(hub_op), .hub_operand(hub_operand),
		.hub_ack(hub_ack), .hub_result(hub_result), .hub_carry(hub_carry), .busy(busy),
		.exec_done(exec_done));
	hub_model hub (.pclk(pclk), .presetn(presetn), .hub_req(hub_req), .delay(delay),
		.result_val(result_val), .carry_val(carry_val), .hub_ack(hub_ack), .hub_result(hub_result),
		.hub_carry(hub_carry));

	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	always @(posedge pclk) begin
		if (busy === 1'b1) busy_cycles++;
		if (exec_done === 1'b1) done_pulses++;
		if (hub_req === 1'b1) begin
			seen_op      <= hub_op;
			seen_operand <= hub_operand;
		end
	end

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", name, e, g);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int   n;
		logic ready;
		n = 0;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			ready = pready;
			rd    = prdata;
			err   = pslverr;
			n++;
		end while (ready !== 1'b1 && n < 20);
		psel    <= 1'b0;
		penable <= 1'b0;
		if (ready !== 1'b1) begin
			mismatches++;
			wrap_up();
		end
	endtask

	function automatic logic [31:0] ins(logic [5:0] o, logic [2:0] zcr, logic i, logic [3:0] c,
			logic [8:0] d, logic [8:0] s);
		return {o, zcr, i, c, d, s};
	endfunction

	function automatic logic [31:0] st(logic c, logic z, logic [8:0] pc, logic ex);
		return {7'h0, pc, 12'h0, ex, c, z, 1'b0};
	endfunction

	task automatic run(input logic [31:0] word);
		int n;
		n = 0;
		apb(1'b1, INSTR_OFS, word);
		busy_cycles = 0;
		done_pulses = 0;
		apb(1'b1, CTRL_OFS, 32'h1);
		apb(1'b1, STATUS_OFS, 32'h0);
		chk("busy_write_err", 32'h1, {31'h0, err});
		do begin
			apb(1'b0, STATUS_OFS, 32'h0);
			n++;
		end while (rd[STAT_BUSY_BIT] !== 1'b0 && n < 20);
		if (rd[STAT_BUSY_BIT] !== 1'b0) begin
			mismatches++;
			wrap_up();
		end
		chk("exec_done_pulses", 32'd1, 32'(done_pulses));
	endtask

	task automatic load(input logic [31:0] d, input logic [1:0] sf);
		apb(1'b1, RAM_ADDR_OFS, 32'h5);
		apb(1'b1, RAM_DATA_OFS, d);
		apb(1'b1, RAM_DATA_OFS, 32'h33);
		apb(1'b1, STATUS_OFS, st(sf[1], sf[0], 9'h0, 1'b0));
	endtask

	task automatic ram5(input logic [31:0] e);
		apb(1'b1, RAM_ADDR_OFS, 32'h5);
		apb(1'b0, RAM_DATA_OFS, 32'h0);
		chk("ram_dest", e, rd);
	endtask

	task automatic dj(input logic [31:0] d, input logic [2:0] zcr, input logic i, input logic [8:0] s,
			input logic [3:0] c, input logic [1:0] sf);
		logic [31:0] r;
		logic        go, tk;
		r  = d - 32'h1;
		go = c[sf];
		tk = go && (r != 32'h0);
		load(d, sf);
		run(ins(DECREMENT_BRANCH_NONZERO_OPC, zcr, i, c, 9'h5, s));
		chk("dec_status", st((go && zcr[1]) ? (d == 32'h0) : sf[1], (go && zcr[2]) ? (r == 32'h0) : sf[0], tk ? (i ? s : 9'h33) : 9'h1, go), rd);
		chk("dec_cycles", (go && !tk) ? 32'd8 : 32'd4, 32'(busy_cycles));
		ram5((go && zcr[0]) ? r : d);
	endtask

	task automatic hb(input logic [2:0] op, input logic [4:0] dl, input logic [31:0] res, input logic cy);
		delay      <= dl;
		result_val <= res;
		carry_val  <= cy;
		load(32'h1234, 2'b00);
		run(ins(SHARED_HUB_OPERATION_OPC, op, 1'b1, 4'hf, 9'h5, {6'h0, op}));
		chk("hub_op", {29'h0, op}, {29'h0, seen_op});
		chk("hub_operand", 32'h1234, seen_operand);
		chk("hub_cycles", (dl < 5'd2) ? 32'd7 : 32'd6 + 32'(dl), 32'(busy_cycles));
		chk("hub_status", st(op[1] & cy, op[2] & (res == 32'h0), 9'h1, 1'b1), rd);
		ram5(op[0] ? res : 32'h1234);
	endtask

	initial begin
		presetn    = 1'b0;
		psel       = 1'b0;
		penable    = 1'b0;
		pwrite     = 1'b0;
		paddr      = 8'h00;
		pwdata     = 32'h0;
		delay      = 5'h0;
		result_val = 32'h0;
		carry_val  = 1'b0;
		mismatches = 0;
		num_checks = 0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, STATUS_OFS, 32'h0);
		chk("status_reset", 32'h0, rd);
		for (int f = 0; f < 4; f++) begin
			for (int k = 0; k < 16; k++) begin
				cnd = k[3:0];
				fl  = f[1:0];
				apb(1'b1, STATUS_OFS, st(fl[1], fl[0], 9'h0, 1'b0));
				run(ins(6'h00, 3'b111, 1'b1, cnd, 9'h5, 9'h7));
				chk("cond_status", st(fl[1], fl[0], 9'h1, cnd[fl]), rd);
				chk("cond_cycles", 32'd4, 32'(busy_cycles));
			end
		end
		dj(32'h1, 3'b111, 1'b1, 9'h1a, 4'hf, 2'b00);
		dj(32'h0, 3'b111, 1'b1, 9'h1a, 4'hf, 2'b00);
		dj(32'h3, 3'b001, 1'b0, 9'h6, 4'hf, 2'b11);
		dj(32'h5, 3'b110, 1'b1, 9'h10, 4'hf, 2'b00);
		dj(32'h1, 3'b111, 1'b1, 9'h1a, 4'h0, 2'b11);
		for (int k = 0; k < 8; k++) begin
			hb(k[2:0], (k == 7) ? 5'd16 : 5'(k * 2), k[0] ? 32'h0 : 32'h55, k[2]);
		end
		apb(1'b1, RAM_ADDR_OFS, 32'h1ef);
		apb(1'b1, RAM_DATA_OFS, 32'hab);
		chk("ram_last_err", 32'h0, {31'h0, err});
		apb(1'b1, RAM_DATA_OFS, 32'hcd);
		chk("ram_special_err", 32'h1, {31'h0, err});
		apb(1'b0, 8'h40, 32'h0);
		chk("unmapped_err", 32'h1, {31'h0, err});
		wrap_up();
	end
endmodule
